// file: pkg/agsu_pkg.sv
// Shared constants for the address generation and stack unit
package agsu_pkg;
    localparam int PC_W = 15;
    localparam int STACK_DEPTH = 16;
    localparam int STACK_W = 53;
    localparam int SP_W = 4;
    localparam int NIB_W = 4;
    localparam int RAM_ADDR_W = 13;
    localparam int LUT_ADDR_W = 16;
    localparam int MASK_W = 8;
    localparam int NUM_IRQ = 8;
    localparam logic [14:0] RESET_VECTOR = 15'h0000;
    localparam logic [14:0] IRQ_VECTOR_BASE = 15'h0004;
    localparam logic [14:0] CODE_START = 15'h0024;
    localparam logic [14:0] LUT_BASE = 15'h4000;
    localparam logic [14:0] PAGE_SPAN = 15'h0800;
    localparam logic [3:0] CODE_PAGE_RESET = 4'h0;
    localparam logic [3:0] RAM_PAGE_RESET = 4'h0;
    localparam logic [3:0] WORKREG_PAGE_RESET = 4'h0;
    localparam logic [3:0] BANK_LOW_RESET = 4'h0;
    localparam logic [1:0] BANK_HIGH_RESET = 2'h0;
    localparam logic [3:0] LOOKUP_PTR_RESET = 4'h0;
    localparam int MASK_TABLE = 0;
    localparam int MASK_BANK = 1;
    localparam int MASK_WORKREG = 2;
    localparam int MASK_CODE_PAGE = 3;
    localparam int MASK_RAM_PAGE = 4;
    localparam int MASK_ACC = 5;
    localparam int MASK_CARRY = 6;
    // Stack entry field positions (lsb)
    localparam int ST_PC = 0;
    localparam int ST_TAB = 15;
    localparam int ST_BKL = 31;
    localparam int ST_BKH = 35;
    localparam int ST_WRP = 37;
    localparam int ST_CPG = 41;
    localparam int ST_RPG = 45;
    localparam int ST_ACC = 48;
    localparam int ST_CF = 52;
endpackage

// file: hdl/lifo_stack.sv
// Sixteen-level wrapping LIFO used for context save
`timescale 1ns/1ns
`default_nettype none
module lifo_stack (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic push_i,
    input wire logic pop_i,
    input wire logic [agsu_pkg::STACK_W-1:0] push_data_i,
    output logic [agsu_pkg::STACK_W-1:0] top_data_o
);
    logic [agsu_pkg::STACK_W-1:0] mem [agsu_pkg::STACK_DEPTH];
    logic [agsu_pkg::SP_W-1:0] sp;

    // Pointer wraps at sixteen, oldest entry is overwritten, no overflow flag
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            sp <= '0;
        end else if (push_i) begin
            sp <= sp + 4'h1;
        end else if (pop_i) begin
            sp <= sp - 4'h1;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (push_i) begin
            mem[sp] <= push_data_i;
        end
    end

    assign top_data_o = mem[sp - 4'h1];
endmodule
`default_nettype wire

// file: hdl/addr_gen_stack_unit.sv
// Program counter, vectors, context stack and ROM/RAM address generation
// Operation
// - 15-bit program counter over 32K words
// - Reset and interrupt load vector directly
// - Addresses 0000h-0023h reserved for vectors
// - Eight vectors four apart, fixed priority
// - Stack is 16 by 53 bits LIFO
// - Call or interrupt pushes full context
// - Plain return restores program counter only
// - Masked return restores selected fields too
// - Stack wraps, overwrites oldest, no overflow
// - Sixteen 2K pages from code page register
// - Conditional branches stay in current page
// - Lookup table at 4000h-7FFFh, nibble elements
// - Four pointer nibbles form element address
// - Element address is four times offset word
// - RAM is 40 banks of 128 nibbles
// - Indirect address from banks, page, pointer
// - Eight RAM pages, page bit 3 reserved
// - Working registers map onto banks 0 and 1
// - Workreg page selects sixteen-register window
// - Immediate logic ops only target working registers
// - Direct address is banks plus 7-bit offset
// - Workreg address is page and register number
`timescale 1ns/1ns
`default_nettype none
module addr_gen_stack_unit (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic step_i,
    input wire logic jump_i,
    input wire logic call_i,
    input wire logic branch_i,
    input wire logic [10:0] target_i,
    input wire logic [agsu_pkg::NUM_IRQ-1:0] irq_req_i,
    input wire logic return_op_i,
    input wire logic masked_return_op_i,
    input wire logic [agsu_pkg::MASK_W-1:0] return_mask_i,
    input wire logic wr_code_page_sel_i,
    input wire logic wr_ram_page_sel_i,
    input wire logic wr_workreg_page_sel_i,
    input wire logic wr_bank_select_low_i,
    input wire logic wr_bank_select_high_i,
    input wire logic [3:0] wr_lookup_ptr_i,
    input wire logic [3:0] wr_data_i,
    input wire logic [3:0] acc_i,
    input wire logic carry_flag_i,
    input wire logic [6:0] direct_offset_i,
    input wire logic [3:0] target_workreg_i,
    input wire logic [3:0] pointer_workreg_value_i,
    input wire logic lookup_read_op_i,
    input wire logic [1:0] ram_mode_i,
    input wire logic imm_logic_op_i,
    input wire logic [15:0] rom_data_i,
    output logic [agsu_pkg::PC_W-1:0] pc_o,
    output logic [agsu_pkg::PC_W-1:0] rom_addr_o,
    output logic [agsu_pkg::RAM_ADDR_W-1:0] ram_addr_o,
    output logic [3:0] lookup_nibble_o,
    output logic lookup_wr_o,
    output logic [3:0] code_page_sel_o,
    output logic [3:0] ram_page_sel_o,
    output logic [3:0] workreg_page_sel_o,
    output logic [3:0] bank_select_low_o,
    output logic [1:0] bank_select_high_o,
    output logic [15:0] lookup_addr_o,
    output logic restore_acc_o,
    output logic [3:0] acc_restore_o,
    output logic restore_carry_o,
    output logic carry_restore_o,
    output logic bank_error_o
);
    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [14:0] pc;
    logic [3:0] code_page_sel;
    logic [3:0] ram_page_sel;
    logic [3:0] workreg_page_sel;
    logic [3:0] bank_select_low;
    logic [1:0] bank_select_high;
    logic [3:0] lookup_ptr_n0;
    logic [3:0] lookup_ptr_n1;
    logic [3:0] lookup_ptr_n2;
    logic [3:0] lookup_ptr_n3;
    logic [agsu_pkg::STACK_W-1:0] push_word;
    logic [agsu_pkg::STACK_W-1:0] top_word;
    logic irq_take;
    logic [2:0] irq_idx;
    logic push;
    logic pop;
    logic [14:0] next_pc;
    logic [15:0] lut_addr;
    logic [12:0] next_ram_addr;
    logic [7:0] mask;
    logic lookup_wr_pend;

    // ------------------------------------------------------------
    // Interrupt priority
    // ------------------------------------------------------------
    always_comb begin
        irq_take = 1'b0;
        irq_idx = 3'h0;
        for (int i = agsu_pkg::NUM_IRQ - 1; i >= 0; i--) begin
            if (irq_req_i[i]) begin
                irq_take = 1'b1;
                irq_idx = 3'(i);
            end
        end
    end

    assign push = step_i && (call_i || irq_take);
    assign pop = step_i && !irq_take && (return_op_i || masked_return_op_i);
    assign mask = masked_return_op_i ? return_mask_i : 8'h00;

    // Context word pushed on call or interrupt entry
    assign push_word = {carry_flag_i, acc_i, ram_page_sel[2:0], code_page_sel, workreg_page_sel,
                        bank_select_high, bank_select_low, lookup_ptr_n3, lookup_ptr_n2,
                        lookup_ptr_n1, lookup_ptr_n0,
                        (call_i && !irq_take) ? pc + 15'h1 : next_pc};

    lifo_stack u_stack (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .push_i(push),
        .pop_i(pop),
        .push_data_i(push_word),
        .top_data_o(top_word)
    );

    // ------------------------------------------------------------
    // Program counter
    // ------------------------------------------------------------
    always_comb begin
        next_pc = pc + 15'h1;
        if (jump_i || call_i) begin
            next_pc = {code_page_sel, target_i};
        end else if (branch_i) begin
            next_pc = {pc[14:11], target_i};
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            pc <= agsu_pkg::RESET_VECTOR;
        end else if (step_i) begin
            if (irq_take) begin
                pc <= agsu_pkg::IRQ_VECTOR_BASE + {10'h0, irq_idx, 2'h0};
            end else if (pop) begin
                pc <= top_word[agsu_pkg::ST_PC +: 15];
            end else if (!lookup_read_op_i) begin
                pc <= next_pc;
            end
        end
    end

    // ------------------------------------------------------------
    // Page and bank registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            code_page_sel <= agsu_pkg::CODE_PAGE_RESET;
        end else if (pop && mask[agsu_pkg::MASK_CODE_PAGE]) begin
            code_page_sel <= top_word[agsu_pkg::ST_CPG +: 4];
        end else if (wr_code_page_sel_i) begin
            code_page_sel <= wr_data_i;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            ram_page_sel <= agsu_pkg::RAM_PAGE_RESET;
        end else if (pop && mask[agsu_pkg::MASK_RAM_PAGE]) begin
            ram_page_sel <= {1'b0, top_word[agsu_pkg::ST_RPG +: 3]};
        end else if (wr_ram_page_sel_i) begin
            ram_page_sel <= {1'b0, wr_data_i[2:0]};
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            workreg_page_sel <= agsu_pkg::WORKREG_PAGE_RESET;
        end else if (pop && mask[agsu_pkg::MASK_WORKREG]) begin
            workreg_page_sel <= top_word[agsu_pkg::ST_WRP +: 4];
        end else if (wr_workreg_page_sel_i) begin
            workreg_page_sel <= wr_data_i;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            bank_select_low <= agsu_pkg::BANK_LOW_RESET;
            bank_select_high <= agsu_pkg::BANK_HIGH_RESET;
        end else if (pop && mask[agsu_pkg::MASK_BANK]) begin
            bank_select_low <= top_word[agsu_pkg::ST_BKL +: 4];
            bank_select_high <= top_word[agsu_pkg::ST_BKH +: 2];
        end else begin
            if (wr_bank_select_low_i) begin
                bank_select_low <= wr_data_i;
            end
            if (wr_bank_select_high_i) begin
                bank_select_high <= wr_data_i[1:0];
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            lookup_ptr_n0 <= agsu_pkg::LOOKUP_PTR_RESET;
            lookup_ptr_n1 <= agsu_pkg::LOOKUP_PTR_RESET;
            lookup_ptr_n2 <= agsu_pkg::LOOKUP_PTR_RESET;
            lookup_ptr_n3 <= agsu_pkg::LOOKUP_PTR_RESET;
        end else if (pop && mask[agsu_pkg::MASK_TABLE]) begin
            lookup_ptr_n0 <= top_word[agsu_pkg::ST_TAB +: 4];
            lookup_ptr_n1 <= top_word[agsu_pkg::ST_TAB + 4 +: 4];
            lookup_ptr_n2 <= top_word[agsu_pkg::ST_TAB + 8 +: 4];
            lookup_ptr_n3 <= top_word[agsu_pkg::ST_TAB + 12 +: 4];
        end else begin
            if (wr_lookup_ptr_i[0]) begin
                lookup_ptr_n0 <= wr_data_i;
            end
            if (wr_lookup_ptr_i[1]) begin
                lookup_ptr_n1 <= wr_data_i;
            end
            if (wr_lookup_ptr_i[2]) begin
                lookup_ptr_n2 <= wr_data_i;
            end
            if (wr_lookup_ptr_i[3]) begin
                lookup_ptr_n3 <= wr_data_i;
            end
        end
    end

    // ------------------------------------------------------------
    // Address generation
    // ------------------------------------------------------------
    assign lut_addr = {lookup_ptr_n3, lookup_ptr_n2, lookup_ptr_n1, lookup_ptr_n0};

    always_comb begin
        case (ram_mode_i)
            2'h1: next_ram_addr = {5'h00, workreg_page_sel, target_workreg_i};
            2'h2: next_ram_addr = {bank_select_high, bank_select_low, ram_page_sel[2:0],
                                   pointer_workreg_value_i};
            default: next_ram_addr = {bank_select_high, bank_select_low, direct_offset_i};
        endcase
        // Immediate logic operations are forced onto the working register window
        if (imm_logic_op_i) begin
            next_ram_addr = {5'h00, workreg_page_sel, target_workreg_i};
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            ram_addr_o <= '0;
            rom_addr_o <= agsu_pkg::RESET_VECTOR;
            lookup_addr_o <= '0;
            bank_error_o <= 1'b0;
        end else begin
            ram_addr_o <= next_ram_addr;
            // Table reads fetch word (addr/4 + 4000h)
            rom_addr_o <= lookup_read_op_i ? (agsu_pkg::LUT_BASE | {1'b0, lut_addr[15:2]}) : pc;
            lookup_addr_o <= lut_addr;
            bank_error_o <= ({bank_select_high, bank_select_low} > 6'h27);
        end
    end

    // Nibble select from the fetched word; written to RAM next cycle
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            lookup_nibble_o <= '0;
            lookup_wr_pend <= 1'b0;
            lookup_wr_o <= 1'b0;
        end else begin
            // Strobe waits one cycle so it stands together with the nibble
            lookup_wr_pend <= lookup_read_op_i;
            lookup_wr_o <= lookup_wr_pend;
            lookup_nibble_o <= rom_data_i[{lookup_addr_o[1:0], 2'b00} +: 4];
        end
    end

    // Registered views and restore strobes for the accumulator and carry
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            pc_o <= agsu_pkg::RESET_VECTOR;
            code_page_sel_o <= '0;
            ram_page_sel_o <= '0;
            workreg_page_sel_o <= '0;
            bank_select_low_o <= '0;
            bank_select_high_o <= '0;
            restore_acc_o <= 1'b0;
            acc_restore_o <= '0;
            restore_carry_o <= 1'b0;
            carry_restore_o <= 1'b0;
        end else begin
            pc_o <= pc;
            code_page_sel_o <= code_page_sel;
            ram_page_sel_o <= ram_page_sel;
            workreg_page_sel_o <= workreg_page_sel;
            bank_select_low_o <= bank_select_low;
            bank_select_high_o <= bank_select_high;
            restore_acc_o <= pop && mask[agsu_pkg::MASK_ACC];
            acc_restore_o <= top_word[agsu_pkg::ST_ACC +: 4];
            restore_carry_o <= pop && mask[agsu_pkg::MASK_CARRY];
            carry_restore_o <= top_word[agsu_pkg::ST_CF];
        end
    end
endmodule
`default_nettype wire

// file: testbench/agsu_checker.sv
// Port assertions for the address generation and stack unit
`timescale 1ns/1ns
`default_nettype none
module agsu_checker (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic step_i,
    input wire logic jump_i,
    input wire logic call_i,
    input wire logic branch_i,
    input wire logic return_op_i,
    input wire logic masked_return_op_i,
    input wire logic [10:0] target_i,
    input wire logic [7:0] irq_req_i,
    input wire logic [7:0] return_mask_i,
    input wire logic lookup_read_op_i,
    input wire logic [1:0] ram_mode_i,
    input wire logic imm_logic_op_i,
    input wire logic [6:0] direct_offset_i,
    input wire logic [3:0] target_workreg_i,
    input wire logic [14:0] pc_o,
    input wire logic [12:0] ram_addr_o,
    input wire logic lookup_wr_o,
    input wire logic [3:0] ram_page_sel_o,
    input wire logic restore_acc_o
);
    logic [4:0] ctl;
    logic quiet;
    logic [14:0] vec;
    assign ctl = {jump_i, call_i, branch_i, return_op_i, masked_return_op_i};
    assign quiet = step_i && irq_req_i == 8'h00;
    // Vector of the highest-priority pending request
    always_comb begin
        vec = 15'h0000;
        for (int i = 7; i >= 0; i--) begin
            if (irq_req_i[i]) begin
                vec = 15'(4 + 4 * i);
            end
        end
    end
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    reset_pc_a:
        assert property ($fell(rst_i) |-> pc_o == 15'h0000) else $error("pc not cleared");
    far_jump_a:
        assert property (quiet && (ctl == 5'h10 || ctl == 5'h08) |-> ##2 pc_o[10:0] == $past(target_i, 2))
            else $error("jump target lost");
    branch_page_a:
        assert property (quiet && ctl == 5'h04 |-> ##2 pc_o == {$past(pc_o[14:11]), $past(target_i, 2)})
            else $error("branch left page");
    irq_vector_a:
        assert property (step_i && irq_req_i != 8'h00 |-> ##2 pc_o == $past(vec, 2)) else $error("wrong vector");
    plain_return_a:
        assert property (quiet && ctl == 5'h02 |=> (!restore_acc_o) [*2]) else $error("plain return restored");
    masked_acc_a:
        assert property (quiet && ctl == 5'h01 && return_mask_i[5] |-> ##[1:2] restore_acc_o)
            else $error("acc not restored");
    lookup_strobe_a:
        assert property (lookup_wr_o == $past(lookup_read_op_i, 2)) else $error("table strobe misplaced");
    direct_addr_a:
        assert property (ram_mode_i[0] == ram_mode_i[1] && !imm_logic_op_i |=> ram_addr_o[6:0] == $past(direct_offset_i))
            else $error("direct offset wrong");
    workreg_addr_a:
        assert property ((ram_mode_i == 2'h1 || imm_logic_op_i) |=>
            ram_addr_o[12:8] == 5'h00 && ram_addr_o[3:0] == $past(target_workreg_i)) else $error("workreg address wrong");
    page_reserved_a:
        assert property (ram_page_sel_o[3] == 1'b0) else $error("ram page bit 3 set");
endmodule
bind addr_gen_stack_unit agsu_checker checker_i (.*);
`default_nettype wire

// file: testbench/rom_model.sv
// Behavioural program store answering the unit's fetch address
`timescale 1ns/1ns
`default_nettype none
module rom_model (
    input wire logic [14:0] addr_i,
    output logic [15:0] data_o
);
    // Asynchronous 32K by 16 array holding a fixed address pattern
    assign data_o = {addr_i[7:0] ^ 8'h96, addr_i[14:7]};
endmodule
`default_nettype wire

// file: testbench/addr_gen_stack_unit_tb_top.sv
// Self-checking bench for the address generation and stack unit
`timescale 1ns/1ns
`default_nettype none
module addr_gen_stack_unit_tb_top;
    typedef struct {logic [14:0] pc; logic [15:0] tab; logic [3:0] bl, workreg_page_select, cp, acc; logic [2:0] rp; logic [1:0] bh;
        logic cf;} ctx_s;
    logic sys_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic step_i = 1'b0, lookup_read_op_i = 1'b0, imm_logic_op_i = 1'b0, carry_flag_i = 1'b0;
    logic jump_i, call_i, branch_i, return_op_i, masked_return_op_i;
    logic wr_code_page_sel_i, wr_ram_page_sel_i, wr_workreg_page_sel_i, wr_bank_select_low_i, wr_bank_select_high_i;
    logic [3:0] wr_lookup_ptr_i;
    logic [4:0] ctl = 5'h00;
    logic [8:0] wstb = 9'h000;
    logic [10:0] target_i = 11'h000;
    logic [7:0] irq_req_i = 8'h00, return_mask_i = 8'h00;
    logic [3:0] wr_data_i = 4'h0, acc_i = 4'h0, target_workreg_i = 4'h0, pointer_workreg_value_i = 4'h0;
    logic [6:0] direct_offset_i = 7'h00;
    logic [1:0] ram_mode_i = 2'h0, bank_select_high_o;
    logic [15:0] rom_data_i, lookup_addr_o, d;
    logic [14:0] pc_o, rom_addr_o, w;
    logic [12:0] ram_addr_o;
    logic [3:0] lookup_nibble_o, code_page_sel_o, ram_page_sel_o, workreg_page_sel_o, bank_select_low_o, acc_restore_o;
    logic lookup_wr_o, restore_acc_o, restore_carry_o, carry_restore_o, bank_error_o;
    ctx_s m = '{default: '0};
    ctx_s stk[$];
    int bad_count = 0;
    int total_checks = 0;
    logic [31:0] lfsr = 32'hde598673;
    assign {jump_i, call_i, branch_i, return_op_i, masked_return_op_i} = ctl;
    assign {wr_lookup_ptr_i, wr_bank_select_high_i, wr_bank_select_low_i, wr_workreg_page_sel_i, wr_ram_page_sel_i,
        wr_code_page_sel_i} = wstb;
    always #50 sys_clk_i = ~sys_clk_i;
    addr_gen_stack_unit DUT (.*);
    rom_model rom_i (.addr_i(rom_addr_o), .data_o(rom_data_i));
    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction
    task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
        total_checks++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic print_verdict();
        if (bad_count == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Strobe k: code page, ram page, workreg page, bank low, bank high, pointer nibbles 0-3
    task automatic wreg(input int k, input logic [3:0] v);
        @(negedge sys_clk_i);
        wstb = 9'h001 << k;
        wr_data_i = v;
        @(negedge sys_clk_i);
        wstb = 9'h000;
        case (k)
            0: m.cp = v;
            1: m.rp = v[2:0];
            2: m.workreg_page_select = v;
            3: m.bl = v;
            4: m.bh = v[1:0];
            default: m.tab[(k - 5) * 4 +: 4] = v;
        endcase
    endtask
    task automatic rregs();
        for (int k = 0; k < 9; k++) begin
            wreg(k, 4'(rnd()));
        end
    endtask
    // Kind: 0 step, 1 jump, 2 call, 3 branch, 4 return, 5 masked return
    task automatic op(input int kind, input logic [7:0] irq, input logic [7:0] msk);
        ctx_s c;
        logic [7:0] eff;
        logic sa, sc, vc;
        logic [3:0] va;
        {sa, sc, vc, va} = 7'h00;
        eff = (kind == 5) ? msk : 8'h00;
        @(negedge sys_clk_i);
        ctl = (kind == 0) ? 5'h00 : 5'h10 >> (kind - 1);
        step_i = 1'b1;
        irq_req_i = irq;
        return_mask_i = msk;
        target_i = 11'(rnd());
        acc_i = 4'(rnd());
        carry_flag_i = ^rnd();
        c = m;
        c.pc = m.pc + 15'h0001;
        c.acc = acc_i;
        c.cf = carry_flag_i;
        if (irq != 8'h00 || kind == 2) begin
            stk.push_back(c);
        end
        if (irq != 8'h00) begin
            for (int i = 7; i >= 0; i--) begin
                if (irq[i]) begin
                    m.pc = 15'(4 + 4 * i);
                end
            end
        end else if (kind == 1 || kind == 2) begin
            m.pc = {m.cp, target_i};
        end else if (kind == 3) begin
            m.pc = {m.pc[14:11], target_i};
        end else if (kind >= 4) begin
            c = stk.pop_back();
            m.pc = c.pc;
            m.tab = eff[0] ? c.tab : m.tab;
            {m.bh, m.bl} = eff[1] ? {c.bh, c.bl} : {m.bh, m.bl};
            m.workreg_page_select = eff[2] ? c.workreg_page_select : m.workreg_page_select;
            m.cp = eff[3] ? c.cp : m.cp;
            m.rp = eff[4] ? c.rp : m.rp;
        end else begin
            m.pc = c.pc;
        end
        if (stk.size() > 16) begin
            stk.delete(0);
        end
        repeat (2) begin
            @(negedge sys_clk_i);
            {ctl, step_i, irq_req_i} = 14'h0000;
            if (restore_acc_o === 1'b1) begin
                {sa, va} = {1'b1, acc_restore_o};
            end
            if (restore_carry_o === 1'b1) begin
                {sc, vc} = {1'b1, carry_restore_o};
            end
        end
        chk("pc", m.pc, pc_o);
        chk("context", {m.tab, m.cp, 1'b0, m.rp, m.workreg_page_select, m.bh, m.bl}, {lookup_addr_o, code_page_sel_o,
            ram_page_sel_o, workreg_page_sel_o, bank_select_high_o, bank_select_low_o});
        chk("restore", {eff[6], eff[5], eff[6] & c.cf, eff[5] ? c.acc : 4'h0}, {sc, sa, vc, va});
    endtask
    initial begin
        #1000000;
        bad_count++;
        print_verdict();
    end
    initial begin
        repeat (3) @(negedge sys_clk_i);
        rst_i = 1'b0;
        chk("reset pc", 15'h0000, pc_o);
        for (int i = 0; i < 12; i++) begin
            wreg(0, 4'(rnd()));
            op(i % 4, 8'h00, 8'h00);
        end
        for (int i = 0; i < 8; i++) begin
            op(4 * (i % 2), (8'h01 << i) | (8'(rnd()) & (8'hfe << i)), 8'h00);
        end
        for (int i = 0; i < 36; i++) begin
            rregs();
            op(i < 20 ? 2 : 4 + i % 2, 8'h00, 8'(rnd()));
        end
        for (int i = 0; i < 24; i++) begin
            rregs();
            @(negedge sys_clk_i);
            ram_mode_i = 2'(i);
            imm_logic_op_i = (i % 5 == 4);
            direct_offset_i = 7'(rnd());
            target_workreg_i = 4'(rnd());
            pointer_workreg_value_i = 4'(rnd());
            repeat (2) @(negedge sys_clk_i);
            if (imm_logic_op_i || ram_mode_i == 2'h1) begin
                chk("workreg address", {m.workreg_page_select, target_workreg_i}, ram_addr_o);
            end else if (ram_mode_i == 2'h2) begin
                chk("indirect address", {m.bh, m.bl, m.rp, pointer_workreg_value_i}, ram_addr_o);
            end else begin
                chk("direct address", {m.bh, m.bl, direct_offset_i}, ram_addr_o);
            end
            chk("bank error", {m.bh, m.bl} > 6'h27, bank_error_o);
        end
        for (int i = 0; i < 8; i++) begin
            rregs();
            @(negedge sys_clk_i);
            lookup_read_op_i = 1'b1;
            w = 15'h4000 + 15'(m.tab[15:2]);
            d = {w[7:0] ^ 8'h96, w[14:7]};
            @(negedge sys_clk_i);
            lookup_read_op_i = 1'b0;
            chk("table word", {w, 1'b0}, {rom_addr_o, lookup_wr_o});
            @(negedge sys_clk_i);
            chk("table nibble", {d[m.tab[1:0] * 4 +: 4], 1'b1}, {lookup_nibble_o, lookup_wr_o});
        end
        print_verdict();
    end
endmodule
`default_nettype wire
